//--- logic/dbd_pkg.sv
// constants and types shared by the dimming device end and the host end
package dbd_pkg;

  // ****************************************************************
  // clocks and timing
  // ****************************************************************
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_KHZ       = CLK_HZ / 1000;
  localparam int SAMPLE_HZ     = 10_000_000;
  localparam int DIRECT_HZ     = 5_000_000;
  localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int DIRECT_DIV    = CLK_HZ / DIRECT_HZ;
  localparam int TIMEOUT_MS    = 24;
  localparam int TIMEOUT_TICKS = TIMEOUT_MS * (SAMPLE_HZ / 1000);
  localparam int MIN_PULSE_NS  = 400;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * (CLK_HZ / 1_000_000)
                                  + 999) / 1000;
  localparam int DIRECT_STAGES = 6;
  localparam int FULL_SCALE    = 65536;

  // ****************************************************************
  // brightness source selection
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_DUTY   = 2'b00,
    MODE_MULT   = 2'b01,
    MODE_REG    = 2'b10,
    MODE_DIRECT = 2'b11
  } dbd_mode_e;

  // ****************************************************************
  // lookup tables indexed by 3-bit selectors
  // ****************************************************************
  localparam int SLOPE_MS [8] = '{0, 1, 2, 52, 105, 210, 315, 511};
  // switch point as a 16-bit fraction of full brightness (n/32)
  localparam logic [15:0] SW_POINT [8] = '{16'h8000, 16'h6800, 16'h5000,
    16'h4000, 16'h3800, 16'h3000, 16'h2800, 16'h2000};
  // 4096 * 65536 / switch point, to stretch the pwm range to full
  localparam logic [15:0] SW_RECIP [8] = '{16'h2000, 16'h2762, 16'h3333,
    16'h4000, 16'h4925, 16'h5555, 16'h6666, 16'h8000};
  // current slope gain in q10
  localparam logic [10:0] GAIN_Q10 [8] = '{11'h400, 11'h418, 11'h430,
    11'h448, 11'h460, 11'h478, 11'h490, 11'h4A8};
  localparam int RECIP_SHIFT = 12;
  localparam int GAIN_SHIFT  = 10;
  localparam int CUR_SHIFT   = 4;

  // cycles per brightness lsb, rounded down, never below one
  function automatic int slope_cycles(input logic [2:0] sel);
    int c;
    c = (SLOPE_MS[sel] * CLK_KHZ) / FULL_SCALE;
    return (c < 1) ? 1 : c;
  endfunction

  // ****************************************************************
  // host register map and control fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BRT  = 8'h04;
  localparam logic [7:0] REG_CUR  = 8'h08;
  localparam logic [7:0] REG_PHI  = 8'h0C;
  localparam logic [7:0] REG_PLO  = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam int CTL_MODE   = 0;
  localparam int CTL_SLOPE  = 2;
  localparam int CTL_HYB    = 5;
  localparam int CTL_GAIN   = 6;
  localparam int CTL_ISLOPE = 9;
  localparam int CTL_PLL    = 12;
  localparam int CTL_RUN    = 13;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [15:0] BRT_RST  = 16'h0000;
  localparam logic [11:0] CUR_RST  = 12'h000;
  localparam int STAT_BOOST = 16;

endpackage

//--- logic/dbd_link_if.sv
// link between the host pwm/config source and the dimming device
`timescale 1ns/1ps
interface dbd_link_if;
  logic        pwm_in;
  logic [15:0] brightness;
  logic [11:0] current_set;
  logic [1:0]  mode;
  logic [2:0]  slope_sel;
  logic        hybrid_en;
  logic [2:0]  gain_sel;
  logic [2:0]  islope_sel;
  logic        pll_en;
  logic [15:0] meas_duty;
  logic        boost_adapt_en;

  modport dev (
    input  pwm_in, brightness, current_set, mode, slope_sel, hybrid_en,
    input  gain_sel, islope_sel, pll_en,
    output meas_duty, boost_adapt_en
  );
  modport host (
    output pwm_in, brightness, current_set, mode, slope_sel, hybrid_en,
    output gain_sel, islope_sel, pll_en,
    input  meas_duty, boost_adapt_en
  );
endinterface

//--- logic/dbd_sloper.sv
// brightness sloper: steps one lsb at a fixed interval toward the target
`timescale 1ns/1ps
module dbd_sloper #(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] target,
  input  wire logic [2:0]   slope_sel,
  input  wire logic         bypass,
  output logic      [W-1:0] value
);
  // ****************************************************************
  // step pacing
  // ****************************************************************
  logic [15:0] cnt_q;
  logic [W-1:0] val_q;
  logic [15:0] interval;

  if (W < 1 || W > 16) begin : g_chk
    $error("dbd_sloper: width must be 1..16");
  end

  assign interval = 16'(dbd_pkg::slope_cycles(slope_sel) - 1);
  assign value    = val_q;

  // one interval for both directions, so ramps up and down match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
      val_q <= '0;
    end else if (bypass || slope_sel == 3'h0) begin
      cnt_q <= 16'h0000;
      val_q <= target; // no ramp
    end else if (val_q != target) begin
      if (cnt_q >= interval) begin
        cnt_q <= 16'h0000;
        val_q <= (val_q < target) ? val_q + 1'b1 : val_q - 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end else begin
      cnt_q <= 16'h0000;
    end
  end
endmodule

//--- logic/dbd_device.sv
// display-mode brightness path: detector, mode select, slope, hybrid
// Functional notes
// - two-bit selector picks brightness source
// - input-duty mode uses 16-bit measured duty
// - period measured rising edge to rising edge
// - input sampled at 10 MHz
// - 24 ms without rising edge is timeout
// - host holds input high 24 ms for full
// - host pulses high and low at least 400 ns
// - register mode uses brightness value only
// - multiply mode: measured duty times brightness
// - direct mode samples at 5 MHz or pll
// - direct output lags input five to six ticks
// - direct mode bypasses slope and hybrid
// - host keeps direct duty below full on
// - boost adaptive off at direct full on
// - ramp time from 3-bit slope selector
// - same ramp time up and down
// - hybrid only when enable bit is one
// - hybrid: pwm low range, current high range
// - switch point from 3-bit selector
// - current slope gain from 3-bit selector
// - host sets current to avoid saturation
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dbd_device #(
  parameter int TIMEOUT_TICKS = dbd_pkg::TIMEOUT_TICKS,
  parameter int PLL_DIV       = dbd_pkg::SAMPLE_DIV
) (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  dbd_link_if.dev     link,
  output logic [15:0] led_duty,
  output logic [11:0] led_current,
  output logic        led_pwm_direct,
  output logic        direct_active
);
  localparam int DS = dbd_pkg::DIRECT_STAGES;

  if (TIMEOUT_TICKS < 2 || TIMEOUT_TICKS >= (1 << 20)) begin : g_chk_to
    $error("dbd_device: timeout ticks out of range");
  end
  if (PLL_DIV < 2 || PLL_DIV > 255) begin : g_chk_pll
    $error("dbd_device: pll divider out of range");
  end

  // ****************************************************************
  // input synchroniser and level filter
  // ****************************************************************
  logic [2:0] sync_q;
  logic       lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], link.pwm_in};
    end
  end

  // a change counts only once the second and third stage agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      lvl_q <= sync_q[2];
    end
  end

  // ****************************************************************
  // sampling ticks
  // ****************************************************************
  logic [4:0] cnt10_q;
  logic [7:0] dcnt_q;
  logic       tick10;
  logic       dtick;
  logic [7:0] dlimit;

  assign tick10 = (cnt10_q == 5'(dbd_pkg::SAMPLE_DIV - 1));
  assign dlimit = link.pll_en ? 8'(PLL_DIV - 1)
                              : 8'(dbd_pkg::DIRECT_DIV - 1);
  assign dtick  = (dcnt_q >= dlimit);

  // detector samples at 10 MHz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt10_q <= 5'h00;
    end else begin
      cnt10_q <= tick10 ? 5'h00 : cnt10_q + 5'h01;
    end
  end

  // direct mode tick: 5 MHz, or the pll rate when enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcnt_q <= 8'h00;
    end else begin
      dcnt_q <= dtick ? 8'h00 : dcnt_q + 8'h01;
    end
  end

  // ****************************************************************
  // period and high-time counters
  // ****************************************************************
  logic        prev_q;
  logic [19:0] per_q;
  logic [19:0] hi_q;
  logic        seen_q;
  logic        timeout_q;
  logic        rise;
  logic        to_hit;

  assign rise   = tick10 && lvl_q && !prev_q;
  assign to_hit = tick10 && !rise && !timeout_q &&
                  (per_q == 20'(TIMEOUT_TICKS - 1));

  // counts restart on each rising edge: one period per edge pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q    <= 1'b0;
      per_q     <= 20'h00000;
      hi_q      <= 20'h00000;
      seen_q    <= 1'b0;
      timeout_q <= 1'b1;
    end else if (tick10) begin
      prev_q <= lvl_q;
      if (rise) begin
        per_q     <= 20'h00001;
        hi_q      <= 20'h00001;
        seen_q    <= 1'b1;
        timeout_q <= 1'b0;
      end else if (to_hit) begin
        per_q     <= per_q + 20'h00001;
        seen_q    <= 1'b0;
        timeout_q <= 1'b1; // no edge for 24 ms
      end else if (!timeout_q) begin
        per_q <= per_q + 20'h00001;
        hi_q  <= hi_q + {19'h00000, lvl_q};
      end
    end
  end

  // ****************************************************************
  // duty divider: quotient = high * 65536 / period
  // ****************************************************************
  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } dbd_div_e;

  dbd_div_e    div_q;
  logic [20:0] rem_q;
  logic [19:0] den_q;
  logic [15:0] quo_q;
  logic [4:0]  bit_q;
  logic [15:0] duty_q;
  logic [20:0] rem2;
  logic        take;

  assign rem2 = {rem_q[19:0], 1'b0};
  assign take = (rem2 >= {1'b0, den_q});

  // timeout resolves a steady input to 0% or 100%
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= DIV_IDLE;
      rem_q  <= 21'h000000;
      den_q  <= 20'h00000;
      quo_q  <= 16'h0000;
      bit_q  <= 5'h00;
      duty_q <= 16'h0000;
    end else if (timeout_q) begin
      div_q  <= DIV_IDLE;
      duty_q <= lvl_q ? 16'hFFFF : 16'h0000;
    end else begin
      case (div_q)
        DIV_IDLE: begin
          if (rise && seen_q) begin
            rem_q <= {1'b0, hi_q};
            den_q <= per_q;
            quo_q <= 16'h0000;
            bit_q <= 5'h10;
            div_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          rem_q <= take ? rem2 - {1'b0, den_q} : rem2;
          quo_q <= {quo_q[14:0], take};
          bit_q <= bit_q - 5'h01;
          if (bit_q == 5'h01) begin
            duty_q <= {quo_q[14:0], take}; // 16-bit measured duty
            div_q  <= DIV_IDLE;
          end
        end
        default: div_q <= DIV_IDLE;
      endcase
    end
  end

  assign link.meas_duty = duty_q;

  // ****************************************************************
  // source select and slope
  // ****************************************************************
  logic [31:0] prod;
  logic [15:0] target;
  logic [15:0] sloped;
  logic        direct;

  assign direct = (link.mode == dbd_pkg::MODE_DIRECT);
  assign prod   = duty_q * link.brightness;

  always_comb begin
    case (link.mode)
      dbd_pkg::MODE_DUTY: target = duty_q;
      dbd_pkg::MODE_MULT: target = prod[31:16];
      dbd_pkg::MODE_REG:  target = link.brightness;
      default:            target = 16'h0000;
    endcase
  end

  // direct mode skips the ramp entirely
  dbd_sloper #(
    .W (16)
  ) u_slope (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .target    (target),
    .slope_sel (link.slope_sel),
    .bypass    (direct),
    .value     (sloped)
  );

  // ****************************************************************
  // hybrid pwm and current dimming
  // ****************************************************************
  logic [15:0] sw_pt;
  logic [31:0] stretch;
  logic [15:0] above;
  logic [22:0] cur_add;
  logic [13:0] cur_sum;
  logic [15:0] duty_d;
  logic [11:0] cur_d;

  assign sw_pt   = dbd_pkg::SW_POINT[link.gain_sel];
  assign stretch = sloped * dbd_pkg::SW_RECIP[link.gain_sel];
  assign above   = sloped - sw_pt;
  assign cur_add = 23'(above[15:dbd_pkg::CUR_SHIFT]
                   * dbd_pkg::GAIN_Q10[link.islope_sel]);
  assign cur_sum = {2'b00, link.current_set}
                   + 14'(cur_add >> dbd_pkg::GAIN_SHIFT);

  // current is clamped at full code rather than wrapping
  always_comb begin
    duty_d = sloped;
    cur_d  = link.current_set;
    if (link.hybrid_en && !direct) begin
      if (sloped < sw_pt) begin
        // pwm range: fixed current, duty stretched to full
        duty_d = (stretch[31:28] != 4'h0) ? 16'hFFFF
                 : stretch[27:dbd_pkg::RECIP_SHIFT];
      end else begin
        // current range: full duty, current grows with gain
        duty_d = 16'hFFFF;
        cur_d  = (cur_sum[13:12] != 2'b00) ? 12'hFFF : cur_sum[11:0];
      end
    end
  end

  // ****************************************************************
  // direct pass-through and boost control
  // ****************************************************************
  logic [DS-1:0] pipe_q;
  logic [15:0]   led_duty_q;
  logic [11:0]   led_cur_q;
  logic          led_dir_q;
  logic          boost_q;

  // six stages give a five to six tick lag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pipe_q <= '0;
    end else if (dtick) begin
      pipe_q <= {pipe_q[DS-2:0], lvl_q};
    end
  end

  // led outputs and boost flag are registered so downstream sees no combinational glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_duty_q <= 16'h0000;
      led_cur_q  <= 12'h000;
      led_dir_q  <= 1'b0;
      boost_q    <= 1'b1;
    end else begin
      led_duty_q <= direct ? 16'h0000 : duty_d;
      led_cur_q  <= cur_d;
      led_dir_q  <= direct && pipe_q[DS-1];
      boost_q    <= !(direct && timeout_q && lvl_q);
    end
  end

  assign led_duty            = led_duty_q;
  assign led_current         = led_cur_q;
  assign led_pwm_direct      = led_dir_q;
  assign direct_active       = direct;
  assign link.boost_adapt_en = boost_q;
endmodule

//--- logic/dbd_host.sv
// host end: ahb-lite register slave, pwm source and config driver
`timescale 1ns/1ps
module dbd_host #(
  parameter int PW = 24
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  dbd_link_if.host         link
);
  if (PW < 8 || PW > 32) begin : g_chk
    $error("dbd_host: pulse width field out of range");
  end

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  logic [13:0]   ctrl_q;
  logic [15:0]   brt_q;
  logic [11:0]   cur_q;
  logic [PW-1:0] phi_q;
  logic [PW-1:0] plo_q;
  logic          wr_q;
  logic [7:0]    addr_q;
  logic [31:0]   rdata_q;
  logic [31:0]   rd_d;
  logic          acc;

  assign acc       = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // unmapped offsets read zero and ignore writes
  always_comb begin
    case (haddr[7:0])
      dbd_pkg::REG_CTRL: rd_d = {18'h00000, ctrl_q};
      dbd_pkg::REG_BRT:  rd_d = {16'h0000, brt_q};
      dbd_pkg::REG_CUR:  rd_d = {20'h00000, cur_q};
      dbd_pkg::REG_PHI:  rd_d = 32'(phi_q);
      dbd_pkg::REG_PLO:  rd_d = 32'(plo_q);
      dbd_pkg::REG_STAT: rd_d = {15'h0000, link.boost_adapt_en,
                                 link.meas_duty};
      default:           rd_d = 32'h00000000;
    endcase
  end

  // address phase is captured; read data is ready for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_q   <= acc && hwrite;
      addr_q <= haddr[7:0];
      if (acc && !hwrite) begin
        rdata_q <= rd_d;
      end
    end
  end

  // data phase write; hsize is taken as a full word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= dbd_pkg::CTRL_RST;
      brt_q  <= dbd_pkg::BRT_RST;
      cur_q  <= dbd_pkg::CUR_RST; // chosen by software for headroom
      phi_q  <= '0;
      plo_q  <= '0;
    end else if (wr_q) begin
      case (addr_q)
        dbd_pkg::REG_CTRL: ctrl_q <= hwdata[13:0];
        dbd_pkg::REG_BRT:  brt_q  <= hwdata[15:0];
        dbd_pkg::REG_CUR:  cur_q  <= hwdata[11:0];
        dbd_pkg::REG_PHI:  phi_q  <= hwdata[PW-1:0];
        dbd_pkg::REG_PLO:  plo_q  <= hwdata[PW-1:0];
        default: ;
      endcase
    end
  end

  assign link.mode        = ctrl_q[dbd_pkg::CTL_MODE +: 2];
  assign link.slope_sel   = ctrl_q[dbd_pkg::CTL_SLOPE +: 3];
  assign link.hybrid_en   = ctrl_q[dbd_pkg::CTL_HYB];
  assign link.gain_sel    = ctrl_q[dbd_pkg::CTL_GAIN +: 3];
  assign link.islope_sel  = ctrl_q[dbd_pkg::CTL_ISLOPE +: 3];
  assign link.pll_en      = ctrl_q[dbd_pkg::CTL_PLL];
  assign link.brightness  = brt_q;
  assign link.current_set = cur_q;

  // ****************************************************************
  // pwm source
  // ****************************************************************
  typedef enum logic [0:0] {
    PH_LOW  = 1'b0,
    PH_HIGH = 1'b1
  } dbd_ph_e;

  localparam logic [PW-1:0] MINP = PW'(dbd_pkg::MIN_PULSE_CYC);

  dbd_ph_e       ph_q;
  logic [PW-1:0] pcnt_q;
  logic          pwm_q;
  logic [PW-1:0] hi_eff;
  logic [PW-1:0] lo_eff;
  logic          dir;

  assign dir = (ctrl_q[dbd_pkg::CTL_MODE +: 2] == dbd_pkg::MODE_DIRECT);

  // short pulses are widened to 400 ns; direct mode never steady high
  always_comb begin
    hi_eff = (phi_q != '0 && phi_q < MINP) ? MINP : phi_q;
    lo_eff = (plo_q != '0 && plo_q < MINP) ? MINP : plo_q;
    if (dir && plo_q == '0 && phi_q != '0) begin
      lo_eff = MINP;
    end
  end

  // zero low time holds the input high outside direct mode, past the 24 ms timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q   <= PH_LOW;
      pcnt_q <= '0;
      pwm_q  <= 1'b0;
    end else if (!ctrl_q[dbd_pkg::CTL_RUN] || hi_eff == '0) begin
      ph_q   <= PH_LOW;
      pcnt_q <= '0;
      pwm_q  <= 1'b0;
    end else if (lo_eff == '0) begin
      ph_q   <= PH_HIGH;
      pcnt_q <= '0;
      pwm_q  <= 1'b1;
    end else begin
      case (ph_q)
        PH_LOW: begin
          if (pcnt_q + 1'b1 >= lo_eff) begin
            ph_q   <= PH_HIGH;
            pcnt_q <= '0;
            pwm_q  <= 1'b1;
          end else begin
            pcnt_q <= pcnt_q + 1'b1;
          end
        end
        PH_HIGH: begin
          if (pcnt_q + 1'b1 >= hi_eff) begin
            ph_q   <= PH_LOW;
            pcnt_q <= '0;
            pwm_q  <= 1'b0;
          end else begin
            pcnt_q <= pcnt_q + 1'b1;
          end
        end
        default: ph_q <= PH_LOW;
      endcase
    end
  end

  assign link.pwm_in = pwm_q;
endmodule

//--- testbench/dbd_link_chk.sv
// assertions on the dimming link and the device outputs
`timescale 1ns/1ps
module dbd_link_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [15:0] brightness,
  input wire logic [11:0] current_set,
  input wire logic [1:0]  mode,
  input wire logic [2:0]  slope_sel,
  input wire logic        hybrid_en,
  input wire logic [15:0] meas_duty,
  input wire logic        boost_adapt_en,
  input wire logic [15:0] led_duty,
  input wire logic [11:0] led_current,
  input wire logic        led_pwm_direct,
  input wire logic        direct_active
);
  logic [49:0] cfg_q;
  logic        same;
  logic [31:0] prod;

  // ****************************************************************
  // helper: settings unchanged since the previous edge
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg_q <= '0;
    else cfg_q <= {brightness, current_set, mode, slope_sel, hybrid_en,
                   meas_duty};
  end
  assign same = cfg_q == {brightness, current_set, mode, slope_sel,
                          hybrid_en, meas_duty};
  // full product so the top half is exact
  assign prod = meas_duty * brightness;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  mode_flag_a: assert property (direct_active == (mode == 2'b11))
    else $error("direct flag does not match mode");
  duty_mode_a: assert property (
    (same && mode == 2'b00 && slope_sel == 3'h0 && !hybrid_en)[*3]
    |-> led_duty == meas_duty) else $error("duty mode output wrong");
  reg_mode_a: assert property (
    (same && mode == 2'b10 && slope_sel == 3'h0 && !hybrid_en)[*3]
    |-> led_duty == brightness) else $error("register mode output wrong");
  mult_mode_a: assert property (
    (same && mode == 2'b01 && slope_sel == 3'h0 && !hybrid_en)[*3]
    |-> led_duty == prod[31:16]) else $error("multiply output wrong");
  pwm_idle_a: assert property (
    mode != 2'b11 ##1 mode != 2'b11 |-> !led_pwm_direct)
    else $error("direct pwm active outside direct mode");
  direct_duty_a: assert property (
    mode == 2'b11 ##1 mode == 2'b11 |-> led_duty == 16'h0000)
    else $error("duty not bypassed in direct mode");
  boost_off_a: assert property (
    $fell(boost_adapt_en) |-> $past(mode) == 2'b11)
    else $error("boost adaptive off outside direct mode");
  flat_cur_a: assert property (
    (same && mode == 2'b10 && slope_sel == 3'h0 &&
     (!hybrid_en || brightness < 16'h2000))[*3]
    |-> led_current == current_set) else $error("current not fixed");
  hyb_top_a: assert property (
    (same && mode == 2'b10 && slope_sel == 3'h0 && hybrid_en &&
     brightness >= 16'h8000)[*3] |-> led_duty == 16'hFFFF)
    else $error("duty not full above switch point");
endmodule

//--- testbench/display_brightness_dimming_tb_top.sv
// bench: ahb host end and dimming device joined over the link
`timescale 1ns/1ps
module display_brightness_dimming_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hrdy, lpd, dact;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] led_duty;
  logic [11:0] led_cur;
  int          n_fail, compares, n;

  dbd_link_if link ();
  // short timeout so the idle detector trips within the run
  dbd_device #(.TIMEOUT_TICKS(200)) dbd_device_i (.hclk(hclk),
    .hresetn(hresetn), .link(link), .led_duty(led_duty),
    .led_current(led_cur), .led_pwm_direct(lpd), .direct_active(dact));
  dbd_host dbd_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(),
    .hrdata(hrdata), .link(link));
  dbd_link_chk dbd_link_chk_i (.hclk(hclk), .hresetn(hresetn),
    .brightness(link.brightness), .current_set(link.current_set),
    .mode(link.mode), .slope_sel(link.slope_sel),
    .hybrid_en(link.hybrid_en), .meas_duty(link.meas_duty),
    .boost_adapt_en(link.boost_adapt_en), .led_duty(led_duty),
    .led_current(led_cur), .led_pwm_direct(lpd), .direct_active(dact));

  // ****************************************************************
  // bus access and comparison tasks
  // ****************************************************************
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one single transfer; waits on hready, never assumes a latency
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h00000000, r);
    cmp("hrdata", e, r);
  endtask
  // device outputs after n settling cycles
  task automatic cv(input int c, input logic [15:0] d,
                    input logic [11:0] i);
    repeat (c) @(posedge hclk);
    cmp("led_duty", {16'h0000, d}, {16'h0000, led_duty});
    cmp("led_current", {20'h00000, i}, {20'h00000, led_cur});
  endtask
  // ramp of 0x40 lsb at 3 cycles each: mid value, then the end value
  task automatic rmp(input logic [15:0] t);
    wr(8'h04, {16'h0000, t});
    repeat (90) @(posedge hclk);
    cmp("ramp_mid", 32'h1, {31'h0, led_duty > 16'h1234 &&
                                   led_duty < 16'h1274});
    cv(150, t, 12'h100);
  endtask
  function automatic logic [31:0] cf(input logic [1:0] m,
    input logic [2:0] s, input logic h, input logic [2:0] g,
    input logic [2:0] i, input logic r);
    return {18'h00000, r, 1'b0, i, g, h, s, m};
  endfunction
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // whole sequence needs about 6000 cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    cr(8'h14, 32'h00010000);
    cr(8'h18, 32'h00000000);
    wr(8'h08, 32'h00000100);
    wr(8'h00, cf(2'b10, 3'h0, 1'b0, 3'h0, 3'h0, 1'b0));
    wr(8'h04, 32'h00001234);
    cv(4, 16'h1234, 12'h100);
    wr(8'h00, cf(2'b10, 3'h2, 1'b0, 3'h0, 3'h0, 1'b0));
    rmp(16'h1274);
    rmp(16'h1234);
    wr(8'h00, cf(2'b10, 3'h0, 1'b1, 3'h3, 3'h7, 1'b0));
    wr(8'h04, 32'h00002000);
    cv(4, 16'h8000, 12'h100);
    wr(8'h04, 32'h00008000);
    cv(4, 16'hFFFF, 12'h5A8);
    wr(8'h00, cf(2'b10, 3'h0, 1'b0, 3'h3, 3'h7, 1'b0));
    cv(4, 16'h8000, 12'h100);
    wr(8'h0C, 32'h00000064);
    wr(8'h10, 32'h0000012C);
    wr(8'h00, cf(2'b00, 3'h0, 1'b0, 3'h0, 3'h0, 1'b1));
    repeat (1500) @(posedge hclk);
    cr(8'h14, 32'h00014000);
    cv(1, 16'h4000, 12'h100);
    wr(8'h00, cf(2'b01, 3'h0, 1'b0, 3'h0, 3'h0, 1'b1));
    cv(4, 16'h2000, 12'h100);
    wr(8'h10, 32'h00000000);
    repeat (2600) @(posedge hclk);
    cr(8'h14, 32'h0001FFFF);
    cv(1, 16'h7FFF, 12'h100);
    wr(8'h00, cf(2'b11, 3'h0, 1'b0, 3'h0, 3'h0, 1'b1));
    @(posedge hclk);
    cr(8'h14, 32'h0000FFFF);
    wr(8'h0C, 32'h00000000);
    repeat (300) @(posedge hclk);
    cr(8'h14, 32'h00010000);
    wr(8'h0C, 32'h00000064);
    wr(8'h10, 32'h0000012C);
    repeat (2) @(posedge link.pwm_in);
    n = 0;
    while (lpd !== 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    cmp("lag", 32'h1, {31'h0, n >= 106 && n <= 126});
    n = 0;
    while (lpd === 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    cmp("high_width", 32'd100, n);
    cv(1, 16'h0000, 12'h100);
    cmp("direct_active", 32'h1, {31'h0, dact});
    wrap_up();
  end
endmodule
